// *** design/exec_pkg.sv ***
package exec_pkg;
  // How it works
  // (RQ1) bank_swap_main flips select bit 8
  // (RQ2) bank_swap_iy flips select bit 24, 3 cycles
  // (RQ3) set_int_mode writes select bits 4-3, 4 cycles
  // (RQ4) mode field 00,01,10,11 gives 0,3,1,2
  // (RQ5) in_word_via_count loads 15-0, count_pair on address
  // (RQ6) selector 000 count, 010 port, 111 pointer
  // (RQ7) input flags: sign, zero, even parity, clear h/n
  // (RQ8) on-chip byte read, no external strobe
  // (RQ9) on-chip address in low byte, rest zero
  // (RQ10) second byte 30h updates flags only
  // (RQ11) in_word_direct loads pointer 15-0, zero-extended address
  // (RQ12) increment_word adds one, width by extended_mode
  // (RQ13) pair and index selectors, both forms 2 cycles
  // (RQ14) in_word_dec stores at pointer, count-1, pointer-2
  // (RQ15) in_word_inc same but pointer plus two
  // (RQ16) block input: zero from counter, subtract set
  // (RQ17) in_word_dec_repeat repeats until counter zero
  // (RQ18) zero start count wraps to 65536 steps
  // (RQ19) interrupt accepted between steps, start pc saved
  // (RQ20) bank select applied live every cycle

  localparam int NUM_REGS = 7;
  localparam logic [2:0] REG_COUNT = 3'd0;
  localparam logic [2:0] REG_PORT = 3'd1;
  localparam logic [2:0] REG_PTR = 3'd2;
  localparam logic [2:0] REG_SP = 3'd3;
  localparam logic [2:0] REG_IX = 3'd4;
  localparam logic [2:0] REG_IY = 3'd5;
  localparam logic [2:0] REG_ACC = 3'd6;

  localparam int SEL_BANK_MAIN = 8;
  localparam int SEL_BANK_IY = 24;
  localparam int SEL_IM_LO = 3;
  localparam logic [31:0] SEL_RESET = 32'h0000_0000;

  localparam int FLG_S = 7;
  localparam int FLG_Z = 6;
  localparam int FLG_H = 4;
  localparam int FLG_P = 2;
  localparam int FLG_N = 1;
  localparam int FLG_C = 0;
  localparam logic [7:0] FLAGS_RESET = 8'h00;

  localparam logic [7:0] OPC_SWAP_MAIN = 8'hd9;
  localparam logic [15:0] OPC_SWAP_IY = 16'hfdd9;
  localparam logic [15:0] OPC_IN_DIRECT = 16'hfddb;
  localparam logic [15:0] OPC_IN_DEC = 16'hedea;
  localparam logic [15:0] OPC_IN_INC = 16'hede2;
  localparam logic [15:0] OPC_IN_DEC_RPT = 16'hedfa;
  localparam logic [7:0] PFX_ED = 8'hed;
  localparam logic [7:0] PFX_DD = 8'hdd;
  localparam logic [7:0] INC_IDX_LOW = 8'h23;
  localparam logic [7:0] ONCHIP_FLAGS_ONLY = 8'h30;
  localparam logic [15:0] PTR_STEP = 16'h0002;

  // cycle counts as printed; io and memory waits come on top
  localparam logic [2:0] CYC_SWAP_MAIN = 3'd2;
  localparam logic [2:0] CYC_SWAP_IY = 3'd3;
  localparam logic [2:0] CYC_SET_IM = 3'd4;
  localparam logic [2:0] CYC_INC = 3'd2;
  localparam logic [2:0] CYC_IN_COUNT = 3'd2;
  localparam logic [2:0] CYC_IN_ONCHIP = 3'd3;
  localparam logic [2:0] CYC_IN_DIRECT = 3'd3;
  localparam logic [2:0] CYC_BLOCK = 3'd2;

  typedef enum logic [3:0] {
    OP_NONE, OP_SWAP_MAIN, OP_SWAP_IY, OP_SET_IM, OP_INC, OP_IN_COUNT,
    OP_IN_ONCHIP, OP_IN_DIRECT, OP_IN_DEC, OP_IN_INC, OP_IN_DEC_RPT
  } op_t;

  typedef enum logic [5:0] {
    S_IDLE = 6'b000001,
    S_EXEC = 6'b000010,
    S_IO = 6'b000100,
    S_ONCHIP = 6'b001000,
    S_MEM = 6'b010000,
    S_STEP = 6'b100000
  } state_t;

  function automatic logic [7:0] in_flags(input logic [7:0] f, input logic [15:0] d,
                                          input logic is_byte);
    logic [7:0] r;
    r = f;
    r[FLG_S] = is_byte ? d[7] : d[15];
    r[FLG_Z] = is_byte ? (d[7:0] == 8'h00) : (d == 16'h0000);
    r[FLG_H] = 1'b0;
    r[FLG_P] = is_byte ? ~^d[7:0] : ~^d;
    r[FLG_N] = 1'b0;
    return r;
  endfunction
endpackage

// *** design/regs_if.sv ***
interface regs_if;
  logic [31:0] sel;
  logic [exec_pkg::NUM_REGS-1:0] wr_en;
  logic [exec_pkg::NUM_REGS-1:0][31:0] wr_val;
  logic [exec_pkg::NUM_REGS-1:0][31:0] val;
  modport bank (input sel, input wr_en, input wr_val, output val);
  modport core (output sel, output wr_en, output wr_val, input val);
endinterface

// *** design/io_sync.sv ***
module io_sync #(
  parameter int WIDTH = 17
) (
  input wire logic i_sys_clk,
  input wire logic i_srst,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] meta_r;

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      meta_r <= '0;
      o_sync <= '0;
    end else begin
      meta_r <= i_async;
      o_sync <= meta_r;
    end
  end
endmodule

// *** design/reg_bank.sv ***
module reg_bank (
  input wire logic i_sys_clk,
  input wire logic i_srst,
  regs_if.bank rif
);
  logic [exec_pkg::NUM_REGS-1:0][1:0][31:0] store_r;

  function automatic logic bank_of(input int idx, input logic [31:0] sel);
    if (idx <= int'(exec_pkg::REG_PTR)) begin
      return sel[exec_pkg::SEL_BANK_MAIN];
    end
    if (idx == int'(exec_pkg::REG_IY)) begin
      return sel[exec_pkg::SEL_BANK_IY];
    end
    return 1'b0;
  endfunction

  for (genvar g = 0; g < exec_pkg::NUM_REGS; g++) begin : g_reg
    // bank picked from the live select bits, no shadow copy [RQ20]
    assign rif.val[g] = store_r[g][bank_of(g, rif.sel)];

    always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
        store_r[g] <= '0;
      end else if (rif.wr_en[g]) begin
        store_r[g][bank_of(g, rif.sel)] <= rif.wr_val[g];
      end
    end
  end
endmodule

// *** design/exec_core.sv ***
module exec_core (
  input wire logic i_sys_clk,
  input wire logic i_srst,
  input wire logic i_start,
  input wire logic i_two_byte,
  input wire logic [15:0] i_opcode,
  input wire logic [15:0] i_operand,
  input wire logic [31:0] i_pc,
  input wire logic i_extended_mode,
  input wire logic i_int_req,
  input wire logic i_io_ack,
  input wire logic [15:0] i_io_data,
  input wire logic [7:0] i_onchip_data,
  input wire logic i_mem_ack,
  output logic o_busy,
  output logic o_done,
  output logic [31:0] o_io_addr,
  output logic o_io_rd,
  output logic o_onchip_rd,
  output logic [31:0] o_mem_addr,
  output logic [15:0] o_mem_wdata,
  output logic o_mem_wr,
  output logic o_int_take,
  output logic [31:0] o_saved_pc,
  output logic [31:0] o_select_reg,
  output logic [7:0] o_flags
);
  regs_if rif ();

  exec_pkg::state_t state_r;
  exec_pkg::op_t op_r;
  exec_pkg::op_t dec_op;
  logic [2:0] cnt_r;
  logic [2:0] dst_r;
  logic byte_hi_r;
  logic flags_only_r;
  logic [15:0] operand_r;
  logic [31:0] pc_r;
  logic [31:0] sel_r;
  logic [7:0] flags_r;
  logic armed_r;
  logic [15:0] data_r;
  logic ack_s;
  logic [15:0] data_s;
  logic io_take;
  logic exec_end;
  logic is_block;
  logic rpt_more;
  logic fin;
  logic [15:0] cnt_dec;

  reg_bank u_bank (
    .i_sys_clk(i_sys_clk),
    .i_srst(i_srst),
    .rif(rif)
  );

  // peripheral answers come from off-chip timing
  io_sync #(.WIDTH(17)) u_sync (
    .i_sys_clk(i_sys_clk),
    .i_srst(i_srst),
    .i_async({i_io_ack, i_io_data}),
    .o_sync({ack_s, data_s})
  );

  assign rif.sel = sel_r; // [RQ20]

  function automatic exec_pkg::op_t decode(input logic two, input logic [15:0] opc);
    if (!two) begin
      if (opc[7:0] == exec_pkg::OPC_SWAP_MAIN) return exec_pkg::OP_SWAP_MAIN; // [RQ1]
      if (opc[7:6] == 2'b00 && opc[3:0] == 4'h3) return exec_pkg::OP_INC; // [RQ13]
      return exec_pkg::OP_NONE;
    end
    if (opc == exec_pkg::OPC_SWAP_IY) return exec_pkg::OP_SWAP_IY; // [RQ2]
    if (opc == exec_pkg::OPC_IN_DIRECT) return exec_pkg::OP_IN_DIRECT; // [RQ11]
    if (opc == exec_pkg::OPC_IN_DEC) return exec_pkg::OP_IN_DEC; // [RQ14]
    if (opc == exec_pkg::OPC_IN_INC) return exec_pkg::OP_IN_INC; // [RQ15]
    if (opc == exec_pkg::OPC_IN_DEC_RPT) return exec_pkg::OP_IN_DEC_RPT; // [RQ17]
    if (opc[15:8] == exec_pkg::PFX_ED && opc[7:5] == 3'b010 && opc[2:0] == 3'b110) begin
      return exec_pkg::OP_SET_IM; // [RQ4]
    end
    if (opc[15:8] == exec_pkg::PFX_ED && opc[7:6] == 2'b00 && opc[2:0] == 3'b000) begin
      return exec_pkg::OP_IN_ONCHIP;
    end
    if (opc[15:8] == exec_pkg::PFX_DD && opc[7:6] == 2'b01 && opc[2:0] == 3'b000) begin
      case (opc[5:3])
        3'b000, 3'b010, 3'b111: return exec_pkg::OP_IN_COUNT; // [RQ6]
        default: return exec_pkg::OP_NONE;
      endcase
    end
    if (opc[15:14] == 2'b11 && opc[12:8] == 5'b11101 && opc[7:0] == exec_pkg::INC_IDX_LOW) begin
      return exec_pkg::OP_INC; // [RQ13]
    end
    return exec_pkg::OP_NONE;
  endfunction

  function automatic logic [2:0] base_cycles(input exec_pkg::op_t op);
    case (op)
      exec_pkg::OP_SWAP_MAIN: return exec_pkg::CYC_SWAP_MAIN;
      exec_pkg::OP_SWAP_IY: return exec_pkg::CYC_SWAP_IY; // [RQ2]
      exec_pkg::OP_SET_IM: return exec_pkg::CYC_SET_IM; // [RQ3]
      exec_pkg::OP_INC: return exec_pkg::CYC_INC; // [RQ13]
      exec_pkg::OP_IN_COUNT: return exec_pkg::CYC_IN_COUNT; // [RQ6]
      exec_pkg::OP_IN_ONCHIP: return exec_pkg::CYC_IN_ONCHIP;
      exec_pkg::OP_IN_DIRECT: return exec_pkg::CYC_IN_DIRECT;
      default: return exec_pkg::CYC_BLOCK;
    endcase
  endfunction

  assign dec_op = decode(i_two_byte, i_opcode);
  assign is_block = (op_r == exec_pkg::OP_IN_DEC) || (op_r == exec_pkg::OP_IN_INC) ||
                    (op_r == exec_pkg::OP_IN_DEC_RPT);
  assign exec_end = (state_r == exec_pkg::S_EXEC) && (cnt_r == 3'd0);
  // a stale acknowledge from the last step must fall before a new one counts
  assign io_take = (state_r == exec_pkg::S_IO) && ack_s && armed_r;
  assign cnt_dec = rif.val[exec_pkg::REG_COUNT][15:0] - 16'h0001;
  // zero start wraps to ffff, so 65536 steps before it reaches zero [RQ18]
  assign rpt_more = (op_r == exec_pkg::OP_IN_DEC_RPT) &&
                    (rif.val[exec_pkg::REG_COUNT][15:0] != 16'h0000); // [RQ17]
  assign fin = (exec_end && (op_r == exec_pkg::OP_NONE || op_r == exec_pkg::OP_SWAP_MAIN ||
                op_r == exec_pkg::OP_SWAP_IY || op_r == exec_pkg::OP_SET_IM ||
                op_r == exec_pkg::OP_INC)) ||
               (io_take && !is_block) || (state_r == exec_pkg::S_ONCHIP) ||
               ((state_r == exec_pkg::S_STEP) && !(rpt_more && !i_int_req));

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      state_r <= exec_pkg::S_IDLE;
      op_r <= exec_pkg::OP_NONE;
      cnt_r <= 3'd0;
      dst_r <= 3'd0;
      byte_hi_r <= 1'b0;
      flags_only_r <= 1'b0;
      operand_r <= 16'h0000;
      pc_r <= 32'h0000_0000;
    end else begin
      case (state_r)
        exec_pkg::S_IDLE: begin
          if (i_start) begin
            op_r <= dec_op;
            cnt_r <= base_cycles(dec_op) - 3'd1;
            operand_r <= (dec_op == exec_pkg::OP_SET_IM) ? i_opcode : i_operand; // [RQ4]
            pc_r <= i_pc; // [RQ19]
            byte_hi_r <= ~i_opcode[3];
            flags_only_r <= (i_opcode[7:0] == exec_pkg::ONCHIP_FLAGS_ONLY); // [RQ10]
            if (!i_two_byte) begin
              dst_r <= {1'b0, i_opcode[5:4]}; // [RQ13]
            end else if (dec_op == exec_pkg::OP_IN_COUNT) begin
              dst_r <= (i_opcode[5:3] == 3'b111) ? exec_pkg::REG_PTR : {1'b0, i_opcode[5:4]};
            end else if (i_opcode[15:8] == exec_pkg::PFX_ED) begin
              dst_r <= (i_opcode[5:4] == 2'b11) ? exec_pkg::REG_ACC : {1'b0, i_opcode[5:4]};
            end else begin
              dst_r <= i_opcode[13] ? exec_pkg::REG_IY : exec_pkg::REG_IX; // [RQ13]
            end
            state_r <= exec_pkg::S_EXEC;
          end
        end
        exec_pkg::S_EXEC: begin
          if (cnt_r != 3'd0) begin
            cnt_r <= cnt_r - 3'd1;
          end else if (op_r == exec_pkg::OP_IN_ONCHIP) begin
            state_r <= exec_pkg::S_ONCHIP;
          end else if (op_r == exec_pkg::OP_IN_COUNT || op_r == exec_pkg::OP_IN_DIRECT ||
                       is_block) begin
            state_r <= exec_pkg::S_IO;
          end else begin
            state_r <= exec_pkg::S_IDLE;
          end
        end
        exec_pkg::S_IO: begin
          if (io_take) begin
            state_r <= is_block ? exec_pkg::S_MEM : exec_pkg::S_IDLE;
          end
        end
        exec_pkg::S_MEM: begin
          if (i_mem_ack) begin
            state_r <= exec_pkg::S_STEP;
          end
        end
        exec_pkg::S_STEP: begin
          if (rpt_more && !i_int_req) begin
            cnt_r <= exec_pkg::CYC_BLOCK - 3'd1;
            state_r <= exec_pkg::S_EXEC; // [RQ17]
          end else begin
            state_r <= exec_pkg::S_IDLE;
          end
        end
        default: state_r <= exec_pkg::S_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      o_io_rd <= 1'b0;
      o_io_addr <= 32'h0000_0000;
      o_onchip_rd <= 1'b0;
      armed_r <= 1'b0;
      data_r <= 16'h0000;
    end else begin
      o_onchip_rd <= 1'b0;
      if (exec_end) begin
        case (op_r)
          exec_pkg::OP_IN_COUNT: begin
            o_io_addr <= rif.val[exec_pkg::REG_COUNT]; // [RQ5]
            o_io_rd <= 1'b1;
          end
          exec_pkg::OP_IN_DIRECT: begin
            o_io_addr <= {16'h0000, operand_r}; // [RQ11]
            o_io_rd <= 1'b1;
          end
          exec_pkg::OP_IN_ONCHIP: begin
            // address shown, but no external strobe [RQ8]
            o_io_addr <= {24'h00_0000, operand_r[7:0]}; // [RQ9]
            o_onchip_rd <= 1'b1;
          end
          exec_pkg::OP_IN_DEC, exec_pkg::OP_IN_INC, exec_pkg::OP_IN_DEC_RPT: begin
            o_io_addr <= rif.val[exec_pkg::REG_PORT]; // [RQ14]
            o_io_rd <= 1'b1;
          end
          default: o_io_rd <= 1'b0;
        endcase
      end
      if (state_r == exec_pkg::S_IO && !ack_s) begin
        armed_r <= 1'b1;
      end
      if (io_take) begin
        o_io_rd <= 1'b0;
        armed_r <= 1'b0;
        data_r <= data_s;
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      o_mem_wr <= 1'b0;
      o_mem_addr <= 32'h0000_0000;
      o_mem_wdata <= 16'h0000;
    end else if (io_take && is_block) begin
      o_mem_wr <= 1'b1;
      o_mem_addr <= rif.val[exec_pkg::REG_PTR]; // [RQ14]
      o_mem_wdata <= data_s;
    end else if (i_mem_ack) begin
      o_mem_wr <= 1'b0;
    end
  end

  always_comb begin
    rif.wr_en = '0;
    rif.wr_val = rif.val;
    if (exec_end && op_r == exec_pkg::OP_INC) begin
      rif.wr_en[dst_r] = 1'b1;
      if (i_extended_mode) begin
        rif.wr_val[dst_r] = rif.val[dst_r] + 32'h0000_0001; // [RQ12]
      end else begin
        rif.wr_val[dst_r][15:0] = rif.val[dst_r][15:0] + 16'h0001; // [RQ12]
      end
    end
    if (io_take && op_r == exec_pkg::OP_IN_COUNT) begin
      rif.wr_en[dst_r] = 1'b1;
      rif.wr_val[dst_r][15:0] = data_s; // [RQ5]
    end
    if (io_take && op_r == exec_pkg::OP_IN_DIRECT) begin
      rif.wr_en[exec_pkg::REG_PTR] = 1'b1;
      rif.wr_val[exec_pkg::REG_PTR][15:0] = data_s; // [RQ11]
    end
    if (state_r == exec_pkg::S_ONCHIP && !flags_only_r) begin // [RQ10]
      rif.wr_en[dst_r] = 1'b1;
      if (byte_hi_r && dst_r != exec_pkg::REG_ACC) begin
        rif.wr_val[dst_r][15:8] = i_onchip_data;
      end else begin
        rif.wr_val[dst_r][7:0] = i_onchip_data;
      end
    end
    if (state_r == exec_pkg::S_MEM && i_mem_ack) begin
      rif.wr_en[exec_pkg::REG_COUNT] = 1'b1;
      rif.wr_val[exec_pkg::REG_COUNT][15:0] = cnt_dec; // [RQ14]
      rif.wr_en[exec_pkg::REG_PTR] = 1'b1;
      if (op_r == exec_pkg::OP_IN_INC) begin
        rif.wr_val[exec_pkg::REG_PTR] =
          rif.val[exec_pkg::REG_PTR] + {16'h0000, exec_pkg::PTR_STEP}; // [RQ15]
      end else begin
        rif.wr_val[exec_pkg::REG_PTR] =
          rif.val[exec_pkg::REG_PTR] - {16'h0000, exec_pkg::PTR_STEP}; // [RQ14] [RQ17]
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      flags_r <= exec_pkg::FLAGS_RESET;
    end else if (io_take && op_r == exec_pkg::OP_IN_COUNT) begin
      flags_r <= exec_pkg::in_flags(flags_r, data_s, 1'b0); // [RQ7]
    end else if (state_r == exec_pkg::S_ONCHIP) begin
      flags_r <= exec_pkg::in_flags(flags_r, {8'h00, i_onchip_data}, 1'b1); // [RQ7]
    end else if (state_r == exec_pkg::S_MEM && i_mem_ack) begin
      flags_r[exec_pkg::FLG_Z] <= (cnt_dec == 16'h0000); // [RQ16]
      flags_r[exec_pkg::FLG_N] <= 1'b1; // [RQ16]
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      sel_r <= exec_pkg::SEL_RESET;
    end else if (exec_end) begin
      case (op_r)
        exec_pkg::OP_SWAP_MAIN: begin
          sel_r[exec_pkg::SEL_BANK_MAIN] <= ~sel_r[exec_pkg::SEL_BANK_MAIN]; // [RQ1]
        end
        exec_pkg::OP_SWAP_IY: begin
          sel_r[exec_pkg::SEL_BANK_IY] <= ~sel_r[exec_pkg::SEL_BANK_IY]; // [RQ2]
        end
        exec_pkg::OP_SET_IM: begin
          case (operand_r[4:3])
            2'b00: sel_r[exec_pkg::SEL_IM_LO +: 2] <= 2'd0; // [RQ3] [RQ4]
            2'b01: sel_r[exec_pkg::SEL_IM_LO +: 2] <= 2'd3; // [RQ4]
            2'b10: sel_r[exec_pkg::SEL_IM_LO +: 2] <= 2'd1; // [RQ4]
            default: sel_r[exec_pkg::SEL_IM_LO +: 2] <= 2'd2; // [RQ4]
          endcase
        end
        default: sel_r <= sel_r;
      endcase
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      o_busy <= 1'b0;
      o_done <= 1'b0;
      o_int_take <= 1'b0;
      o_saved_pc <= 32'h0000_0000;
    end else begin
      o_busy <= (state_r == exec_pkg::S_IDLE) ? i_start : !fin;
      o_done <= fin;
      o_int_take <= 1'b0;
      if (state_r == exec_pkg::S_STEP && rpt_more && i_int_req) begin
        o_int_take <= 1'b1;
        o_saved_pc <= pc_r; // [RQ19]
      end
    end
  end

  assign o_select_reg = sel_r;
  assign o_flags = flags_r;
endmodule

// *** test/io_peer.sv ***
module io_peer (
  input wire logic i_sys_clk,
  input wire logic i_io_rd,
  input wire logic i_mem_wr,
  input wire logic [15:0] i_word,
  input wire logic [3:0] i_dly,
  output logic o_io_ack,
  output logic [15:0] o_io_data,
  output logic o_mem_ack
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] cnt_r;
  logic [4:0] mcnt_r;
  initial begin
    o_io_ack = 1'b0;
    o_io_data = 16'h0;
    o_mem_ack = 1'b0;
    cnt_r = 5'h0;
    mcnt_r = 5'h0;
  end
  always @(posedge i_sys_clk) begin
    if (!i_io_rd) begin
      cnt_r <= 5'h0;
      o_io_ack <= 1'b0;
      // released bus: toggles so stale data never looks valid
      o_io_data <= ~o_io_data;
    end else begin
      cnt_r <= cnt_r + 5'h1;
      if (cnt_r == {1'b0, i_dly}) o_io_data <= i_word;
      // data settles one cycle before ack
      if (cnt_r == {1'b0, i_dly} + 5'h1) o_io_ack <= 1'b1;
    end
    if (i_mem_wr && !o_mem_ack) begin
      mcnt_r <= mcnt_r + 5'h1;
      if (mcnt_r >= {1'b0, i_dly}) o_mem_ack <= 1'b1;
    end else begin
      mcnt_r <= 5'h0;
      o_mem_ack <= 1'b0;
    end
  end
endmodule

// *** test/exec_chk.sv ***
module exec_chk (
  input wire logic i_sys_clk,
  input wire logic i_srst,
  input wire logic i_start,
  input wire logic i_two_byte,
  input wire logic [15:0] i_opcode,
  input wire logic [15:0] i_operand,
  input wire logic [31:0] i_pc,
  input wire logic i_mem_ack,
  input wire logic o_busy,
  input wire logic o_done,
  input wire logic [31:0] o_io_addr,
  input wire logic o_io_rd,
  input wire logic o_onchip_rd,
  input wire logic [31:0] o_mem_addr,
  input wire logic [15:0] o_mem_wdata,
  input wire logic o_mem_wr,
  input wire logic o_int_take,
  input wire logic [31:0] o_saved_pc,
  input wire logic [31:0] o_select_reg,
  input wire logic [7:0] o_flags
);
  logic take;
  logic [31:0] sel_r;
  logic [31:0] pc_r;
  logic [15:0] opc_r;
  logic [15:0] opd_r;
  logic [7:0] flg_r;
  assign take = i_start && !o_busy;
  always_ff @(posedge i_sys_clk) begin
    if (take) begin
      sel_r <= o_select_reg;
      pc_r <= i_pc;
      opc_r <= i_two_byte ? i_opcode : {8'h00, i_opcode[7:0]};
      opd_r <= i_operand;
      flg_r <= o_flags;
    end
  end
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (i_srst);
  a_swap_main_bit: assert property (take && !i_two_byte && i_opcode[7:0] == 8'hd9 |->
    ##[2:4] o_done && o_select_reg == (sel_r ^ 32'h0000_0100) && o_flags == flg_r)
    else $error("main bank swap wrong");
  a_swap_iy_bit: assert property (take && i_two_byte && i_opcode == 16'hfdd9 |->
    ##4 o_done && o_select_reg == (sel_r ^ 32'h0100_0000) && o_flags == flg_r)
    else $error("iy bank swap wrong");
  a_int_mode_map: assert property (take && i_two_byte && i_opcode[15:6] == 10'b1110110101
    && i_opcode[2:0] == 3'b110 |-> ##5 o_done
    && o_select_reg[4:3] == {opc_r[3], opc_r[4] ^ opc_r[3]})
    else $error("interrupt mode wrong");
  a_onchip_quiet: assert property (o_onchip_rd |-> !o_io_rd)
    else $error("external strobe on on-chip read");
  a_onchip_addr: assert property (o_onchip_rd |-> o_io_addr == {24'h0, opd_r[7:0]})
    else $error("on-chip address wrong");
  a_direct_addr: assert property (o_io_rd && opc_r == 16'hfddb |->
    o_io_addr == {16'h0, opd_r})
    else $error("direct address wrong");
  a_mem_hold: assert property (o_mem_wr && !i_mem_ack |=>
    o_mem_wr && $stable(o_mem_addr) && $stable(o_mem_wdata))
    else $error("memory write not held");
  a_int_pc: assert property (o_int_take |-> o_done && o_saved_pc == pc_r)
    else $error("saved pc wrong");
  a_block_flags: assert property (o_done && opc_r inside {16'hedea, 16'hede2, 16'hedfa} |->
    o_flags[1] && o_flags[7] == flg_r[7] && o_flags[4] == flg_r[4] && o_flags[0] == flg_r[0])
    else $error("block flags wrong");
endmodule

bind exec_core exec_chk u_chk (.i_sys_clk, .i_srst, .i_start, .i_two_byte, .i_opcode,
  .i_operand, .i_pc, .i_mem_ack, .o_busy, .o_done, .o_io_addr, .o_io_rd, .o_onchip_rd,
  .o_mem_addr, .o_mem_wdata, .o_mem_wr, .o_int_take, .o_saved_pc, .o_select_reg, .o_flags);

// *** test/tb.sv ***
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_sys_clk, i_srst, i_start, i_two_byte, i_extended_mode, i_int_req;
  logic i_io_ack, i_mem_ack, o_busy, o_done, o_io_rd, o_onchip_rd, o_mem_wr, o_int_take;
  logic [15:0] i_opcode, i_operand, i_io_data, o_mem_wdata, word;
  logic [31:0] i_pc, o_io_addr, o_mem_addr, o_saved_pc, o_select_reg, x, cap_a, exp_sel;
  logic [7:0] i_onchip_data, o_flags, exp_f, d;
  logic [3:0] dly;
  logic seen_io, seen_oc;
  logic [31:0] rg [2][3];
  logic [31:0] aq [$];
  logic [15:0] dq [$];
  int fails, check_count;
  exec_core dut (.i_sys_clk, .i_srst, .i_start, .i_two_byte, .i_opcode, .i_operand, .i_pc,
    .i_extended_mode, .i_int_req, .i_io_ack, .i_io_data, .i_onchip_data, .i_mem_ack, .o_busy,
    .o_done, .o_io_addr, .o_io_rd, .o_onchip_rd, .o_mem_addr, .o_mem_wdata, .o_mem_wr,
    .o_int_take, .o_saved_pc, .o_select_reg, .o_flags);
  io_peer peer (.i_sys_clk, .i_io_rd(o_io_rd), .i_mem_wr(o_mem_wr), .i_word(word),
    .i_dly(dly), .o_io_ack(i_io_ack), .o_io_data(i_io_data), .o_mem_ack(i_mem_ack));
  initial begin
    i_sys_clk = 1'b0;
    forever #5 i_sys_clk = ~i_sys_clk;
  end
  always @(posedge i_sys_clk) begin
    if (o_io_rd || o_onchip_rd) cap_a <= o_io_addr;
    if (o_io_rd) seen_io <= 1'b1;
    if (o_onchip_rd) seen_oc <= 1'b1;
    if (o_mem_wr && i_mem_ack) begin
      aq.push_back(o_mem_addr);
      dq.push_back(o_mem_wdata);
    end
  end
  function logic [31:0] rnd();
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    x = x ^ (x << 5);
    return x;
  endfunction
  function logic [7:0] fin(logic [7:0] f, logic [15:0] v, logic by);
    fin = f;
    fin[7] = by ? v[7] : v[15];
    fin[6] = by ? v[7:0] == 8'h0 : v == 16'h0;
    fin[4] = 1'b0;
    fin[2] = by ? ~^v[7:0] : ~^v;
    fin[1] = 1'b0;
  endfunction
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task close_out;
    $display("checks %0d fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task tend(input string s);
    $display("test %s ends, %0d checks", s, check_count);
  endtask
  task run(input logic two, input logic [15:0] opc, input logic [15:0] opd);
    int n;
    @(negedge i_sys_clk);
    seen_io = 1'b0;
    seen_oc = 1'b0;
    aq.delete();
    dq.delete();
    @(posedge i_sys_clk);
    i_start <= 1'b1;
    i_two_byte <= two;
    i_opcode <= opc;
    i_operand <= opd;
    i_pc <= rnd();
    dly <= {1'b0, x[2:0]};
    @(posedge i_sys_clk);
    i_start <= 1'b0;
    n = 0;
    do begin
      @(posedge i_sys_clk);
      #1;
      n++;
    end while (o_done !== 1'b1 && n < 400);
    chk(o_done, 32'h1);
    chk(o_flags, exp_f);
    chk(o_select_reg, exp_sel);
    chk(o_busy, 32'h0);
    chk(o_int_take, 32'(i_int_req));
  endtask
  task in_word_via_count(input int k, input logic [15:0] w);
    logic [2:0] code;
    logic b;
    code = k == 0 ? 3'b000 : k == 1 ? 3'b010 : 3'b111;
    b = exp_sel[8];
    word <= w;
    exp_f = fin(exp_f, w, 1'b0);
    run(1'b1, 16'hdd40 | {10'h0, code, 3'b000}, 16'h0);
    chk(cap_a, rg[b][0]);
    chk(seen_io, 32'h1);
    rg[b][k][15:0] = w;
  endtask
  task inc(input int k, input logic e);
    logic b;
    b = exp_sel[8];
    i_extended_mode <= e;
    if (k < 3) rg[b][k] = e ? rg[b][k] + 32'h1 : {rg[b][k][31:16], rg[b][k][15:0] + 16'h1};
    run(1'b0, 16'(8'h03 | (k << 4)), 16'h0);
  endtask
  task blk(input logic [15:0] opc, input int n);
    logic b;
    logic [31:0] hl;
    b = exp_sel[8];
    hl = rg[b][2];
    rg[b][0][15:0] = rg[b][0][15:0] - 16'(n);
    rg[b][2] = opc == 16'hede2 ? hl + 32'(2 * n) : hl - 32'(2 * n);
    exp_f[6] = rg[b][0][15:0] == 16'h0;
    exp_f[1] = 1'b1;
    word <= 16'(rnd());
    run(1'b1, opc, 16'h0);
    chk(aq.size(), n);
    chk(cap_a, rg[b][1]);
    for (int i = 0; i < n; i++) begin
      chk(aq[i], opc == 16'hede2 ? hl + 32'(2 * i) : hl - 32'(2 * i));
      chk(dq[i], word);
    end
  endtask
  initial begin
    #200_000;
    fails++;
    close_out;
  end
  initial begin
    x = 32'haf5d;
    fails = 0;
    check_count = 0;
    {i_start, i_two_byte, i_extended_mode, i_int_req} = 4'h0;
    {i_opcode, i_operand, word, i_pc, i_onchip_data, dly} = '0;
    exp_sel = 32'h0;
    exp_f = 8'h0;
    foreach (rg[b, k]) rg[b][k] = 32'h0;
    i_srst = 1'b1;
    repeat (6) @(posedge i_sys_clk);
    i_srst <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      exp_sel[8] = ~exp_sel[8];
      run(1'b0, 16'h00d9, 16'h0);
      exp_sel[24] = ~exp_sel[24];
      run(1'b1, 16'hfdd9, 16'h0);
      exp_sel[4:3] = {i[0], i[1] ^ i[0]};
      run(1'b1, 16'hed46 | 16'(i << 3), 16'hed46 | 16'(i << 3));
    end
    tend("modes");
    for (int i = 0; i < 8; i++) begin
      if (i == 4) begin
        exp_sel[8] = ~exp_sel[8];
        run(1'b0, 16'h00d9, 16'h0);
      end
      in_word_via_count(i % 3, i == 0 ? 16'h0 : i == 1 ? 16'h8000 : 16'(rnd()));
    end
    tend("word input");
    in_word_via_count(0, 16'hffff);
    inc(0, 1'b0);
    in_word_via_count(0, 16'hffff);
    inc(0, 1'b1);
    in_word_via_count(0, 16'h1234);
    for (int k = 1; k < 4; k++) inc(k, x[k]);
    run(1'b1, 16'hdd23, 16'h0);
    run(1'b1, 16'hfd23, 16'h0);
    in_word_via_count(0, 16'(rnd()));
    tend("increment");
    for (int i = 0; i < 6; i++) begin
      d = i == 0 ? 8'h0 : 8'(rnd());
      i_onchip_data <= d;
      exp_f = fin(exp_f, {8'h0, d}, 1'b1);
      if (i % 3 == 0) rg[exp_sel[8]][0][7:0] = d;
      run(1'b1, i % 3 == 0 ? 16'hed08 : i % 3 == 1 ? 16'hed30 : 16'hed38, {8'h0, x[15:8]});
      chk(cap_a, {24'h0, i_operand[7:0]});
      chk({seen_io, seen_oc}, 32'h1);
      in_word_via_count(1, 16'(rnd()));
    end
    tend("on-chip");
    word <= 16'(rnd());
    rg[exp_sel[8]][2][15:0] = 16'(x);
    run(1'b1, 16'hfddb, x[31:16]);
    chk(cap_a, {16'h0, i_operand});
    in_word_via_count(1, 16'(rnd()));
    tend("direct");
    in_word_via_count(0, 16'h0001);
    // pointer still holds the direct load here
    blk(16'hedea, 1);
    in_word_via_count(2, 16'h8000);
    in_word_via_count(0, 16'h0002);
    blk(16'hede2, 1);
    blk(16'hedfa, 1);
    in_word_via_count(0, 16'h0003);
    i_int_req <= 1'b1;
    blk(16'hedfa, 1);
    chk(o_int_take, 32'h1);
    chk(o_saved_pc, i_pc);
    i_int_req <= 1'b0;
    blk(16'hedfa, 2);
    tend("block");
    close_out;
  end
endmodule
